// File: rtl/tlic_cfg.svh
// Constants of the two-level interrupt controller: offsets, fields, vectors, response codes
// What this block does
// R01: Priority mode vectors high requests to 0008h and low requests to 0018h.
// R02: An enabled high request preempts a running low-level handler.
// R03: Every source has its own flag, enable and priority select bit.
// R04: Priority mode enable resets cleared, so compatibility mode is the start.
// R05: Without priority mode, priority selects affect neither masking nor vector.
// R06: Compatibility: peripheral sources need both peripheral and global enable.
// R07: Compatibility: global enable passes core sources; cleared, it blocks all.
// R08: Compatibility: every accepted interrupt vectors to 0008h.
// R09: Setting the priority mode bit in the reset control register starts priority mode.
// R10: Priority mode reads the two global bits as high and low level enables.
// R11: Priority mode: high enable passes every source selected high.
// R12: Priority mode: low sources need both level enables set.
// R13: Flag, enable and applicable global enable all set vector at once.
// R14: Clearing one source enable stops only that source from vectoring.
// R15: Core acknowledge clears the applicable global enable.
// R16: Return from handler sets the applicable global enable again.
// R17: Flags set on every event regardless of any enable.
// R18: Priority mode: cleared high enable blocks every source, low ones too.
// R19: High and low pending together: high vector is presented first.
// R20: Core samples request and vector only at instruction boundaries.
`ifndef TLIC_CFG_SVH
`define TLIC_CFG_SVH
`define TLIC_ADDR_CTRL 8'h00
`define TLIC_ADDR_RESET_CTRL 8'h04
`define TLIC_ADDR_FLAG 8'h08
`define TLIC_ADDR_ENABLE 8'h0C
`define TLIC_ADDR_PRIO 8'h10
`define TLIC_ADDR_PERIPH 8'h14
`define TLIC_ADDR_STATUS 8'h18
`define TLIC_ADDR_EVSET 8'h1C
`define TLIC_BIT_GLOBAL_EN 7
`define TLIC_BIT_PERIPH_EN 6
`define TLIC_BIT_PME 7
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018
`define TLIC_VEC_NONE 16'h0000
`define TLIC_RESP_OKAY 2'h0
`define TLIC_RESP_SLVERR 2'h2
`endif

// File: rtl/tlic_pkg.sv
// Types of the two-level interrupt controller
package tlic_pkg;
  typedef enum logic [1:0] {
    TLIC_LVL_NONE = 2'b00,
    TLIC_LVL_LOW = 2'b01,
    TLIC_LVL_HIGH = 2'b10
  } tlic_level_type;
  typedef struct packed {
    logic request;
    logic high;
    logic [15:0] vector;
  } tlic_core_req_type;
endpackage

// File: rtl/tlic_src_bank.sv
// Per-source bit storage: flag, enable, priority and peripheral class for each source
`timescale 1ns/1ps
`include "tlic_cfg.svh"
module tlic_src_bank #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events from sources
  input wire logic [N-1:0] event_in,
  // Software write port
  input wire logic wr_flag,
  input wire logic wr_enable,
  input wire logic wr_prio,
  input wire logic wr_periph,
  input wire logic [N-1:0] wdata,
  // Stored bits
  output logic [N-1:0] flag_reg,
  output logic [N-1:0] enable_reg,
  output logic [N-1:0] prio_reg,
  output logic [N-1:0] periph_reg
);
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_src
      // Event wins over a software clear in the same cycle
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          flag_reg[i] <= 1'b0;
        else if (event_in[i])
          flag_reg[i] <= 1'b1; // [R17] [R03]
        else if (wr_flag)
          flag_reg[i] <= wdata[i];
      end
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          enable_reg[i] <= 1'b0;
        else if (wr_enable)
          enable_reg[i] <= wdata[i]; // [R03] [R14]
      end
      // Priority selects reset high, matching the usual power-on default
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          prio_reg[i] <= 1'b1;
        else if (wr_prio)
          prio_reg[i] <= wdata[i]; // [R03]
      end
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          periph_reg[i] <= 1'b0;
        else if (wr_periph)
          periph_reg[i] <= wdata[i];
      end
    end
  endgenerate
endmodule

// File: rtl/tlic_top.sv
// Two-level interrupt controller top: AXI4-Lite slave, masking, vector select, core handshake
`timescale 1ns/1ps
`include "tlic_cfg.svh"
module tlic_top #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Source events, one-cycle pulses or levels
  input wire logic [N-1:0] event_in,
  // Core side
  input wire logic core_ack,
  input wire logic core_return,
  output tlic_pkg::tlic_core_req_type core_req_reg
);
  logic [N-1:0] flag_reg;
  logic [N-1:0] enable_reg;
  logic [N-1:0] prio_reg;
  logic [N-1:0] periph_reg;
  logic global_irq_enable_reg;
  logic peripheral_irq_enable_reg;
  logic pme_reg;
  tlic_pkg::tlic_level_type active_reg;
  tlic_pkg::tlic_level_type active_next;
  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_value;
  logic rd_hit;
  logic wr_hit;
  logic [N-1:0] live;
  logic [N-1:0] pass;
  logic want_high;
  logic want_low;
  logic [N-1:0] bank_wdata;
  logic [N-1:0] evset;

  // Decode used by both channels
  function automatic logic addr_known(input logic [7:0] a);
    if (a == `TLIC_ADDR_CTRL)
      addr_known = 1'b1;
    else if (a == `TLIC_ADDR_RESET_CTRL)
      addr_known = 1'b1;
    else if (a == `TLIC_ADDR_FLAG || a == `TLIC_ADDR_ENABLE)
      addr_known = 1'b1;
    else if (a == `TLIC_ADDR_PRIO || a == `TLIC_ADDR_PERIPH)
      addr_known = 1'b1;
    else if (a == `TLIC_ADDR_STATUS || a == `TLIC_ADDR_EVSET)
      addr_known = 1'b1;
    else
      addr_known = 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data latch independently; one write at a time
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_hit = addr_known(awaddr_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else if (wr_go)
    begin
      aw_held_reg <= 1'b0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else
      s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (wr_go)
    begin
      w_held_reg <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else
      s_axi_wready <= !w_held_reg && !s_axi_bvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TLIC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Only byte lane 0 carries register bits
  function automatic logic lane_write(input logic [7:0] a, input logic [7:0] target);
    lane_write = wr_go && wstrb_reg[0] && (a == target);
  endfunction

  assign bank_wdata = wdata_reg[N-1:0];
  assign evset = lane_write(awaddr_reg, `TLIC_ADDR_EVSET) ? bank_wdata : {N{1'b0}};

  tlic_src_bank #(
    .N(N)
  ) u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_in(event_in | evset),
    .wr_flag(lane_write(awaddr_reg, `TLIC_ADDR_FLAG)),
    .wr_enable(lane_write(awaddr_reg, `TLIC_ADDR_ENABLE)),
    .wr_prio(lane_write(awaddr_reg, `TLIC_ADDR_PRIO)),
    .wr_periph(lane_write(awaddr_reg, `TLIC_ADDR_PERIPH)),
    .wdata(bank_wdata),
    .flag_reg(flag_reg),
    .enable_reg(enable_reg),
    .prio_reg(prio_reg),
    .periph_reg(periph_reg)
  );

  // ----------------------------------------------------------------
  // Mode and global enables
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pme_reg <= 1'b0; // [R04]
    else if (lane_write(awaddr_reg, `TLIC_ADDR_RESET_CTRL))
      pme_reg <= wdata_reg[`TLIC_BIT_PME]; // [R09]
  end

  // Acknowledge clears the level taken; return re-enables the level left.
  // Hardware events win over a software write in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      global_irq_enable_reg <= 1'b0;
    else if (core_ack && (!pme_reg || core_req_reg.high))
      global_irq_enable_reg <= 1'b0; // [R15]
    else if (core_return && (!pme_reg || active_reg == tlic_pkg::TLIC_LVL_HIGH))
      global_irq_enable_reg <= 1'b1; // [R16]
    else if (lane_write(awaddr_reg, `TLIC_ADDR_CTRL))
      global_irq_enable_reg <= wdata_reg[`TLIC_BIT_GLOBAL_EN];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      peripheral_irq_enable_reg <= 1'b0;
    else if (core_ack && pme_reg && !core_req_reg.high)
      peripheral_irq_enable_reg <= 1'b0; // [R15]
    else if (core_return && pme_reg && active_reg == tlic_pkg::TLIC_LVL_LOW)
      peripheral_irq_enable_reg <= 1'b1; // [R16]
    else if (lane_write(awaddr_reg, `TLIC_ADDR_CTRL))
      peripheral_irq_enable_reg <= wdata_reg[`TLIC_BIT_PERIPH_EN];
  end

  // Tracks which handler level runs so a return restores the right enable.
  // Nesting deeper than high-over-low is not remembered: returning from
  // the high handler assumes the low handler resumes when the low enable is clear.
  always_comb
  begin
    active_next = active_reg;
    if (core_ack)
      active_next = core_req_reg.high ? tlic_pkg::TLIC_LVL_HIGH : tlic_pkg::TLIC_LVL_LOW;
    else if (core_return)
    begin
      if (active_reg == tlic_pkg::TLIC_LVL_HIGH && pme_reg && !peripheral_irq_enable_reg)
        active_next = tlic_pkg::TLIC_LVL_LOW;
      else
        active_next = tlic_pkg::TLIC_LVL_NONE;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      active_reg <= tlic_pkg::TLIC_LVL_NONE;
    else
      active_reg <= active_next;
  end

  // ----------------------------------------------------------------
  // Masking and vector selection
  // ----------------------------------------------------------------
  assign live = flag_reg & enable_reg; // [R13] [R14]

  always_comb
  begin
    pass = {N{1'b0}};
    want_high = 1'b0;
    want_low = 1'b0;
    if (pme_reg)
    begin
      // High level needs only the high enable; low needs both [R10] [R18]
      want_high = global_irq_enable_reg && |(live & prio_reg); // [R11]
      want_low = global_irq_enable_reg && peripheral_irq_enable_reg
        && |(live & ~prio_reg); // [R12]
    end
    else
    begin
      // Priority selects ignored here [R05]
      pass = live & ~periph_reg & {N{global_irq_enable_reg}}; // [R07]
      pass = pass | (live & periph_reg
        & {N{global_irq_enable_reg && peripheral_irq_enable_reg}}); // [R06]
      want_low = |pass;
    end
  end

  // Request is registered; the core samples it at instruction boundaries [R20]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_req_reg.request <= 1'b0;
      core_req_reg.high <= 1'b0;
      core_req_reg.vector <= `TLIC_VEC_NONE;
    end
    else if (core_ack)
    begin
      // Drop for one cycle so the cleared enable takes effect first
      core_req_reg.request <= 1'b0;
      core_req_reg.high <= 1'b0;
      core_req_reg.vector <= `TLIC_VEC_NONE;
    end
    else if (want_high)
    begin
      core_req_reg.request <= 1'b1; // [R02] [R19]
      core_req_reg.high <= 1'b1;
      core_req_reg.vector <= `TLIC_VEC_HIGH; // [R01]
    end
    else if (want_low)
    begin
      core_req_reg.request <= 1'b1; // [R13]
      core_req_reg.high <= 1'b0;
      core_req_reg.vector <= pme_reg ? `TLIC_VEC_LOW : `TLIC_VEC_HIGH; // [R01] [R08]
    end
    else
    begin
      core_req_reg.request <= 1'b0;
      core_req_reg.high <= 1'b0;
      core_req_reg.vector <= `TLIC_VEC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_hit = addr_known(s_axi_araddr);

  always_comb
  begin
    rd_value = 32'h00000000;
    if (s_axi_araddr == `TLIC_ADDR_CTRL)
    begin
      rd_value[`TLIC_BIT_GLOBAL_EN] = global_irq_enable_reg;
      rd_value[`TLIC_BIT_PERIPH_EN] = peripheral_irq_enable_reg;
    end
    else if (s_axi_araddr == `TLIC_ADDR_RESET_CTRL)
      rd_value[`TLIC_BIT_PME] = pme_reg;
    else if (s_axi_araddr == `TLIC_ADDR_FLAG)
      rd_value[N-1:0] = flag_reg;
    else if (s_axi_araddr == `TLIC_ADDR_ENABLE)
      rd_value[N-1:0] = enable_reg;
    else if (s_axi_araddr == `TLIC_ADDR_PRIO)
      rd_value[N-1:0] = prio_reg;
    else if (s_axi_araddr == `TLIC_ADDR_PERIPH)
      rd_value[N-1:0] = periph_reg;
    else if (s_axi_araddr == `TLIC_ADDR_STATUS)
    begin
      rd_value[1:0] = active_reg;
      rd_value[2] = core_req_reg.request;
      rd_value[3] = core_req_reg.high;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TLIC_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_hit ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end
endmodule

// File: dv/tlic_asserts.sv
// Port checker of the two-level interrupt controller
`timescale 1ns/1ps
`include "tlic_cfg.svh"
module tlic_asserts #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sources and core
  input wire logic [N-1:0] event_in,
  input wire logic core_ack,
  input wire logic core_return,
  input wire tlic_pkg::tlic_core_req_type core_req_reg
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  AST_VEC_HIGH: assert property (core_req_reg.request && core_req_reg.high |->
    core_req_reg.vector == `TLIC_VEC_HIGH) else $error("high request off its vector");
  AST_VEC_LEGAL: assert property (core_req_reg.request |->
    core_req_reg.vector inside {`TLIC_VEC_HIGH, `TLIC_VEC_LOW}) else $error("bad vector");
  AST_IDLE: assert property (!core_req_reg.request |->
    core_req_reg.vector == `TLIC_VEC_NONE && !core_req_reg.high) else $error("idle not clean");
  AST_ACK_DROP: assert property (core_req_reg.request && core_ack |=>
    !core_req_reg.request) else $error("request stands after ack");
  AST_RESET_IDLE: assert property ($rose(aresetn) |->
    !core_req_reg.request && !s_axi_bvalid && !s_axi_rvalid) else $error("busy out of reset");
  AST_WR_ANSWER: assert property (wr_both |-> b_answer)
    else $error("write not answered");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

// File: dv/tlic_core_model.sv
// Processor core partner: takes requests and returns from handlers
`timescale 1ns/1ps
module tlic_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller side
  input wire tlic_pkg::tlic_core_req_type core_req_reg,
  output logic core_ack,
  output logic core_return,
  // Bench control
  input wire logic ack_en,
  input wire logic slow,
  input wire logic ret_go,
  output logic [15:0] taken_vec
);
  logic [1:0] wait_reg;
  // Slow mode stands for a multi-cycle instruction before the boundary
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_ack <= 1'b0;
      core_return <= 1'b0;
      wait_reg <= 2'h0;
      taken_vec <= 16'h0000;
    end
    else
    begin
      core_ack <= 1'b0;
      core_return <= ret_go;
      if (core_req_reg.request && ack_en && !core_ack)
      begin
        if (!slow || wait_reg == 2'h3)
        begin
          core_ack <= 1'b1;
          taken_vec <= core_req_reg.vector;
          wait_reg <= 2'h0;
        end
        else
          wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule

// File: dv/two_level_interrupt_controller_tb.sv
// Testbench of the two-level interrupt controller
`timescale 1ns/1ps
`include "tlic_cfg.svh"
module two_level_interrupt_controller_tb;
  localparam int N = 8;
  localparam logic [1:0] OK = `TLIC_RESP_OKAY;
  localparam logic [1:0] SE = `TLIC_RESP_SLVERR;
  localparam logic [17:0] RQ_0 = 18'h00000;
  localparam logic [17:0] RQ_C = {2'b10, `TLIC_VEC_HIGH};
  localparam logic [17:0] RQ_H = {2'b11, `TLIC_VEC_HIGH};
  localparam logic [17:0] RQ_L = {2'b10, `TLIC_VEC_LOW};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [N-1:0] event_in = 8'h00;
  logic core_ack;
  logic core_return;
  tlic_pkg::tlic_core_req_type core_req_reg;
  logic ack_en = 1'b0;
  logic slow = 1'b0;
  logic ret_go = 1'b0;
  logic [15:0] taken_vec;
  int n_errors = 0;
  int compares = 0;
  tlic_top #(.N(N)) i_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .event_in(event_in),
    .core_ack(core_ack),
    .core_return(core_return),
    .core_req_reg(core_req_reg)
  );
  tlic_core_model i_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .core_req_reg(core_req_reg),
    .core_ack(core_ack),
    .core_return(core_return),
    .ack_en(ack_en),
    .slow(slow),
    .ret_go(ret_go),
    .taken_vec(taken_vec)
  );
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  // ----
  // Access tasks
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    // Late ready: the slave must hold its answer for a cycle
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic ev(input logic [N-1:0] m);
    event_in <= m;
    @(posedge aclk);
    event_in <= 8'h00;
  endtask
  task automatic req(input logic [17:0] e);
    repeat (3) @(posedge aclk);
    chk("core_req", {14'h0, e}, {14'h0, core_req_reg});
  endtask
  task automatic take(input logic [15:0] v);
    ack_en <= 1'b1;
    do
      @(posedge aclk);
    while (!core_ack);
    ack_en <= 1'b0;
    chk("taken_vec", {16'h0, v}, {16'h0, taken_vec});
  endtask
  task automatic ret;
    ret_go <= 1'b1;
    @(posedge aclk);
    ret_go <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TLIC_ADDR_CTRL, 32'h0, OK);
    rd(`TLIC_ADDR_RESET_CTRL, 32'h0, OK);
    rd(`TLIC_ADDR_PRIO, 32'hFF, OK);
    // Lane 0 strobe off: accepted but no register bit may change
    s_axi_wstrb <= 4'hE;
    wr(`TLIC_ADDR_CTRL, 32'h80, OK);
    s_axi_wstrb <= 4'hF;
    rd(`TLIC_ADDR_CTRL, 32'h0, OK);
    rd(8'h20, 32'h0, SE);
    wr(8'h20, 32'hFF, SE);
    ev(8'h01);
    rd(`TLIC_ADDR_FLAG, 32'h01, OK);
    wr(`TLIC_ADDR_PERIPH, 32'hF0, OK);
    wr(`TLIC_ADDR_PRIO, 32'h0F, OK);
    wr(`TLIC_ADDR_ENABLE, 32'h11, OK);
    req(RQ_0);
    wr(`TLIC_ADDR_CTRL, 32'h80, OK);
    req(RQ_C);
    slow <= 1'b1;
    take(`TLIC_VEC_HIGH);
    slow <= 1'b0;
    rd(`TLIC_ADDR_CTRL, 32'h00, OK);
    wr(`TLIC_ADDR_FLAG, 32'h0, OK);
    ret();
    rd(`TLIC_ADDR_CTRL, 32'h80, OK);
    ev(8'h10);
    req(RQ_0);
    wr(`TLIC_ADDR_CTRL, 32'hC0, OK);
    req(RQ_C);
    take(`TLIC_VEC_HIGH);
    wr(`TLIC_ADDR_FLAG, 32'h0, OK);
    ret();
    wr(`TLIC_ADDR_RESET_CTRL, 32'h80, OK);
    rd(`TLIC_ADDR_RESET_CTRL, 32'h80, OK);
    wr(`TLIC_ADDR_CTRL, 32'h80, OK);
    ev(8'h10);
    req(RQ_0);
    wr(`TLIC_ADDR_CTRL, 32'hC0, OK);
    req(RQ_L);
    take(`TLIC_VEC_LOW);
    rd(`TLIC_ADDR_STATUS, 32'h1, OK);
    rd(`TLIC_ADDR_CTRL, 32'h80, OK);
    ev(8'h01);
    req(RQ_H);
    take(`TLIC_VEC_HIGH);
    rd(`TLIC_ADDR_CTRL, 32'h00, OK);
    wr(`TLIC_ADDR_FLAG, 32'h0, OK);
    ret();
    rd(`TLIC_ADDR_CTRL, 32'h80, OK);
    ret();
    rd(`TLIC_ADDR_CTRL, 32'hC0, OK);
    wr(`TLIC_ADDR_CTRL, 32'h40, OK);
    ev(8'h10);
    req(RQ_0);
    wr(`TLIC_ADDR_CTRL, 32'h00, OK);
    wr(`TLIC_ADDR_EVSET, 32'h11, OK);
    wr(`TLIC_ADDR_CTRL, 32'hC0, OK);
    req(RQ_H);
    rd(`TLIC_ADDR_STATUS, 32'hC, OK);
    wr(`TLIC_ADDR_ENABLE, 32'h10, OK);
    req(RQ_L);
    tally_and_finish();
  end
  // Far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end
endmodule
bind tlic_top tlic_asserts #(.N(N)) i_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .event_in(event_in),
  .core_ack(core_ack),
  .core_return(core_return),
  .core_req_reg(core_req_reg)
);
